// [frlc_regs.sv]
// Purpose: APB register bank for collision, transmit count and bit rate display
// Assumes: Framer and detector events arrive on pclk; APB byte address is index times four
// Notes:   Answers every access on the second access cycle
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "frlc_defines.svh"
module frlc_regs (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     frame_start,
    input  wire logic                     in_ac_range,
    input  wire frlc_pkg::frlc_coll_evt_t coll_evt,
    input  wire frlc_pkg::frlc_rate_evt_t rate_evt,
    input  wire logic                     set_default_cmd,
    input  wire logic                     anticoll_mode,
    input  wire logic                     card_idle,
    input  wire logic                     wakeup_cmd,
    output logic [12:0]                   tx_byte_count,
    output logic [2:0]                    tx_split_bits,
    output logic                          tx_parity_off,
    output logic                          parity_irq,
    output logic                          coll_parity_err
);

    frlc_pkg::frlc_regs_t st_r;
    frlc_pkg::frlc_regs_t st_nxt;
    logic [7:0]           coll_disp;
    logic                 coll_par;
    logic                 acc;
    logic                 wr_en;
    logic [2:0]           split_nxt;

    // Word index match, shared by read and write decode
    function automatic logic idx_hit(input logic [7:0] a, input logic [5:0] idx);
        return a[7:2] == idx;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return idx_hit(a, `FRLC_IDX_COLL) || idx_hit(a, `FRLC_IDX_CNT_HI) ||
               idx_hit(a, `FRLC_IDX_CNT_LO) || idx_hit(a, `FRLC_IDX_RATE);
    endfunction

    frlc_coll_capture u_cap (
        .pclk            (pclk),
        .presetn         (presetn),
        .frame_start     (frame_start),
        .in_ac_range     (in_ac_range),
        .set_default_cmd (set_default_cmd),
        .coll_evt        (coll_evt),
        .disp            (coll_disp),
        .par_err         (coll_par)
    );

    assign acc   = psel && penable;
    assign wr_en = acc && pwrite && st_r.pready && !st_r.pslverr;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.par_irq = 1'b0;

        // Access phase: answer on the following edge
        if (acc && !st_r.pready) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !mapped(paddr);
            st_nxt.prdata  = `FRLC_RST_WORD;
            if (!pwrite) begin
                if (idx_hit(paddr, `FRLC_IDX_COLL)) begin
                    st_nxt.prdata[7:0] = coll_disp;
                end else if (idx_hit(paddr, `FRLC_IDX_CNT_HI)) begin
                    st_nxt.prdata[7:0] = st_r.cnt_hi;
                end else if (idx_hit(paddr, `FRLC_IDX_CNT_LO)) begin
                    st_nxt.prdata[7:0] = st_r.cnt_lo;
                end else if (idx_hit(paddr, `FRLC_IDX_RATE)) begin
                    st_nxt.prdata[`FRLC_RATE_MSB:`FRLC_RATE_LSB] = st_r.rate;
                end
            end
        end

        // Write takes effect at the edge where pready is sampled high
        if (wr_en) begin
            if (idx_hit(paddr, `FRLC_IDX_CNT_HI)) begin
                st_nxt.cnt_hi = pwdata[7:0];
            end
            if (idx_hit(paddr, `FRLC_IDX_CNT_LO)) begin
                st_nxt.cnt_lo = pwdata[7:0];
            end
        end

        if (rate_evt.valid) begin
            st_nxt.rate = rate_evt.code;
        end

        if (set_default_cmd) begin
            st_nxt.cnt_hi = `FRLC_RST_BYTE;
            st_nxt.cnt_lo = `FRLC_RST_BYTE;
            st_nxt.rate   = `FRLC_RST_RATE;
        end

        split_nxt      = st_nxt.cnt_lo[`FRLC_SPLIT_MSB:`FRLC_SPLIT_LSB];
        st_nxt.par_off = anticoll_mode && (split_nxt != `FRLC_NO_SPLIT);

        if (wakeup_cmd && anticoll_mode && card_idle &&
            st_r.cnt_lo[`FRLC_SPLIT_MSB:`FRLC_SPLIT_LSB] != `FRLC_NO_SPLIT) begin
            st_nxt.par_irq = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{cnt_hi:  `FRLC_RST_BYTE,
                      cnt_lo:  `FRLC_RST_BYTE,
                      rate:    `FRLC_RST_RATE,
                      prdata:  `FRLC_RST_WORD,
                      pready:  1'b0,
                      pslverr: 1'b0,
                      par_irq: 1'b0,
                      par_off: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata          = st_r.prdata;
    assign pready          = st_r.pready;
    assign pslverr         = st_r.pslverr;
    assign tx_byte_count   = {st_r.cnt_hi, st_r.cnt_lo[`FRLC_NTX_LO_MSB:`FRLC_NTX_LO_LSB]};
    assign tx_split_bits   = st_r.cnt_lo[`FRLC_SPLIT_MSB:`FRLC_SPLIT_LSB];
    assign tx_parity_off   = st_r.par_off;
    assign parity_irq      = st_r.par_irq;
    assign coll_parity_err = coll_par;

    // Checks

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_apb_write_done(logic [5:0] idx);
        psel && penable && pwrite && pready && !pslverr && idx_hit(paddr, idx);
    endsequence

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        s_apb_setup ##1 (psel && penable) |-> ##1 pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no answer on second cycle");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !mapped(paddr)) |=> pready && pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

    property p_read_coll;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && !pready && idx_hit(paddr, `FRLC_IDX_COLL))
            |=> prdata == {24'h00_0000, $past(coll_disp)};
    endproperty
    a_read_coll: assert property (p_read_coll) else $error("collision read mismatch");

    property p_disp_default;
        @(posedge pclk) disable iff (!presetn)
        set_default_cmd |=> coll_disp == 8'h00 && st_r.rate == 4'h0;
    endproperty
    a_disp_default: assert property (p_disp_default) else $error("displays not cleared");

    property p_count_hi;
        @(posedge pclk) disable iff (!presetn)
        (s_apb_write_done(`FRLC_IDX_CNT_HI) and !set_default_cmd)
            |=> tx_byte_count[12:5] == $past(pwdata[7:0]);
    endproperty
    a_count_hi: assert property (p_count_hi) else $error("byte count high mismatch");

    property p_count_lo;
        @(posedge pclk) disable iff (!presetn)
        (s_apb_write_done(`FRLC_IDX_CNT_LO) and !set_default_cmd)
            |=> tx_byte_count[4:0] == $past(pwdata[7:3]) &&
                tx_split_bits == $past(pwdata[2:0]);
    endproperty
    a_count_lo: assert property (p_count_lo) else $error("byte count low or split mismatch");

    property p_no_parity;
        @(posedge pclk) disable iff (!presetn)
        ##1 tx_parity_off == ($past(anticoll_mode) && tx_split_bits != 3'h0);
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("parity suppression wrong");

    property p_wake_par;
        @(posedge pclk) disable iff (!presetn)
        (wakeup_cmd && anticoll_mode && card_idle && tx_split_bits != 3'h0)
            |=> parity_irq;
    endproperty
    a_wake_par: assert property (p_wake_par) else $error("wake-up parity interrupt missing");

    property p_wake_quiet;
        @(posedge pclk) disable iff (!presetn)
        parity_irq |-> $past(wakeup_cmd && anticoll_mode && card_idle && tx_split_bits != 3'h0);
    endproperty
    a_wake_quiet: assert property (p_wake_quiet) else $error("spurious parity interrupt");

    property p_rate_read;
        @(posedge pclk) disable iff (!presetn)
        (rate_evt.valid && !set_default_cmd) ##1
        (psel && penable && !pwrite && !pready && idx_hit(paddr, `FRLC_IDX_RATE) &&
         !rate_evt.valid && !set_default_cmd)
            |=> prdata == {24'h00_0000, $past(rate_evt.code, 2), 4'h0};
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("bit rate read mismatch");

    property p_count_default;
        @(posedge pclk) disable iff (!presetn)
        set_default_cmd |=> tx_byte_count == 13'h0000 && tx_split_bits == 3'h0;
    endproperty
    a_count_default: assert property (p_count_default) else $error("counts not cleared");

    sequence s_read_first(logic [5:0] idx);
        psel && penable && !pwrite && !pready && idx_hit(paddr, idx);
    endsequence

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

    property p_slverr_pulse;
        @(posedge pclk) disable iff (!presetn)
        pslverr |=> !pslverr;
    endproperty
    a_slverr_pulse: assert property (p_slverr_pulse) else $error("pslverr held");

    property p_ready_after_access;
        @(posedge pclk) disable iff (!presetn)
        pready |-> $past(psel && penable);
    endproperty
    a_ready_after_access: assert property (p_ready_after_access) else $error("pready unasked");

    property p_mapped_ok;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && mapped(paddr)) |=> pready && !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");

    property p_prdata_hold;
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable && !pready) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data changed idle");

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

    property p_read_hi;
        @(posedge pclk) disable iff (!presetn)
        s_read_first(`FRLC_IDX_CNT_HI)
            |=> prdata == {24'h00_0000, $past(tx_byte_count[12:5])};
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("count high read mismatch");

    property p_read_lo;
        @(posedge pclk) disable iff (!presetn)
        s_read_first(`FRLC_IDX_CNT_LO)
            |=> prdata == {24'h00_0000, $past(tx_byte_count[4:0]),
                           $past(tx_split_bits)};
    endproperty
    a_read_lo: assert property (p_read_lo) else $error("count low read mismatch");

    property p_read_rate_low;
        @(posedge pclk) disable iff (!presetn)
        s_read_first(`FRLC_IDX_RATE)
            |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h00_0000;
    endproperty
    a_read_rate_low: assert property (p_read_rate_low) else $error("unused rate bits set");

    property p_err_no_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && pslverr && !set_default_cmd)
            |=> $stable(tx_byte_count) && $stable(tx_split_bits);
    endproperty
    a_err_no_write: assert property (p_err_no_write) else $error("refused write stored");

    property p_count_hold;
        @(posedge pclk) disable iff (!presetn)
        (!set_default_cmd && !(psel && penable && pwrite && pready))
            |=> $stable(tx_byte_count) && $stable(tx_split_bits);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counts changed unasked");

    property p_off_split;
        @(posedge pclk) disable iff (!presetn)
        tx_parity_off |-> tx_split_bits != 3'h0;
    endproperty
    a_off_split: assert property (p_off_split) else $error("bad parity off");

    property p_par_on;
        @(posedge pclk) disable iff (!presetn)
        (anticoll_mode && tx_split_bits != 3'h0 && !set_default_cmd &&
         !(psel && penable && pwrite && pready)) |=> tx_parity_off;
    endproperty
    a_par_on: assert property (p_par_on) else $error("parity not suppressed");

    property p_wake_zero;
        @(posedge pclk) disable iff (!presetn)
        (wakeup_cmd && tx_split_bits == 3'h0) |=> !parity_irq;
    endproperty
    a_wake_zero: assert property (p_wake_zero) else $error("interrupt without split");

    property p_rate_load;
        @(posedge pclk) disable iff (!presetn)
        (rate_evt.valid && !set_default_cmd) |=> st_r.rate == $past(rate_evt.code);
    endproperty
    a_rate_load: assert property (p_rate_load) else $error("rate code not stored");

    property p_rate_hold;
        @(posedge pclk) disable iff (!presetn)
        (!rate_evt.valid && !set_default_cmd) |=> $stable(st_r.rate);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate code changed");

endmodule

// [frlc_defines.svh]
// Purpose: Offsets, field positions and reset values of the framing registers
// Assumes: Word index times four is the APB byte address
// Notes:   Definitions only
`ifndef FRLC_DEFINES_SVH
`define FRLC_DEFINES_SVH

// Register word indexes
`define FRLC_IDX_COLL       6'h1c
`define FRLC_IDX_CNT_HI     6'h1d
`define FRLC_IDX_CNT_LO     6'h1e
`define FRLC_IDX_RATE       6'h1f

// Field positions
`define FRLC_CBYTE_MSB      7
`define FRLC_CBYTE_LSB      4
`define FRLC_CBIT_MSB       3
`define FRLC_CBIT_LSB       1
`define FRLC_CPAR_BIT       0
`define FRLC_NTX_LO_MSB     7
`define FRLC_NTX_LO_LSB     3
`define FRLC_SPLIT_MSB      2
`define FRLC_SPLIT_LSB      0
`define FRLC_RATE_MSB       7
`define FRLC_RATE_LSB       4

// Reset and set-default values
`define FRLC_RST_BYTE       8'h00
`define FRLC_RST_RATE       4'h0
`define FRLC_RST_WORD       32'h0000_0000
`define FRLC_NO_SPLIT       3'h0

`endif

// [frlc_pkg.sv]
// Purpose: Types shared by the framing register bank
// Assumes: Single clock domain
// Notes:   Constants live in frlc_defines.svh
package frlc_pkg;

    // Collision report from the receive framer
    typedef struct packed {
        logic       valid;
        logic [3:0] byte_cnt;
        logic [2:0] bit_cnt;
        logic       on_parity;
    } frlc_coll_evt_t;

    // Bit rate detection result
    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } frlc_rate_evt_t;

    // Collision capture state
    typedef struct packed {
        logic       armed;
        logic [7:0] disp;
        logic       par_err;
    } frlc_cap_t;

    // Register bank state
    typedef struct packed {
        logic [7:0]  cnt_hi;
        logic [7:0]  cnt_lo;
        logic [3:0]  rate;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        par_irq;
        logic        par_off;
    } frlc_regs_t;

endpackage

// [frlc_coll_capture.sv]
// Purpose: Catches the first collision of a frame for the collision display
// Assumes: Event inputs are synchronous to pclk
// Notes:   Set-default clears the display and wins over a same-cycle event
`timescale 1ns/1ps
`include "frlc_defines.svh"
module frlc_coll_capture (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    frame_start,
    input  wire logic                    in_ac_range,
    input  wire logic                    set_default_cmd,
    input  wire frlc_pkg::frlc_coll_evt_t coll_evt,
    output logic [7:0]                   disp,
    output logic                         par_err
);

    frlc_pkg::frlc_cap_t st_r;
    frlc_pkg::frlc_cap_t st_nxt;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.par_err = 1'b0;
        if (frame_start) begin
            st_nxt.armed = 1'b1;
        end
        if (coll_evt.valid && st_r.armed) begin
            st_nxt.armed = 1'b0;
            if (in_ac_range) begin
                st_nxt.disp[`FRLC_CBYTE_MSB:`FRLC_CBYTE_LSB] = coll_evt.byte_cnt;
                st_nxt.disp[`FRLC_CBIT_MSB:`FRLC_CBIT_LSB]   = coll_evt.bit_cnt;
                st_nxt.disp[`FRLC_CPAR_BIT]                  = coll_evt.on_parity;
                st_nxt.par_err                               = coll_evt.on_parity;
            end
        end
        if (set_default_cmd) begin
            st_nxt.disp    = `FRLC_RST_BYTE;
            st_nxt.par_err = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{armed: 1'b1, disp: `FRLC_RST_BYTE, par_err: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign disp    = st_r.disp;
    assign par_err = st_r.par_err;

    sequence s_first_coll;
        coll_evt.valid && st_r.armed && in_ac_range && !set_default_cmd;
    endsequence

    property p_coll_fields;
        @(posedge pclk) disable iff (!presetn)
        s_first_coll |=> disp[7:1] == {$past(coll_evt.byte_cnt), $past(coll_evt.bit_cnt)};
    endproperty
    a_coll_fields: assert property (p_coll_fields) else $error("collision position wrong");

    property p_coll_bits;
        @(posedge pclk) disable iff (!presetn)
        s_first_coll |=> disp[3:1] == $past(coll_evt.bit_cnt) && !st_r.armed;
    endproperty
    a_coll_bits: assert property (p_coll_bits) else $error("collision bit count wrong");

    property p_par_first;
        @(posedge pclk) disable iff (!presetn)
        par_err |-> disp[0] && $past(coll_evt.valid && st_r.armed && coll_evt.on_parity);
    endproperty
    a_par_first: assert property (p_par_first) else $error("parity error not first");

    property p_out_of_range;
        @(posedge pclk) disable iff (!presetn)
        (!in_ac_range && !set_default_cmd) |=> $stable(disp);
    endproperty
    a_out_of_range: assert property (p_out_of_range) else $error("display changed out of range");

endmodule

// [frlc_host.sv]
// Purpose: Host model that reaches the register bank over APB
// Assumes: Each transfer is started right after a rising pclk edge
// Notes:   Register data travels in bits 7:0 only
`timescale 1ns/1ps
module frlc_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // One transfer; request held until pready is seen high at an edge, or dropped after 16 edges of access phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err, output logic tmo);
        int n;
        n = 0;
        tmo = 1'b1;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        while (n < 16) begin
            @(posedge pclk);
            n++;
            if (pready === 1'b1) begin
                tmo = 1'b0;
                n = 16;
            end
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the framing register bank
// Assumes: Host model drives APB; bench drives framer events
// Notes:   Events are driven by non-blocking assignment at rising edges
`timescale 1ns/1ps
`include "frlc_defines.svh"
module tb;
    logic                     pclk, presetn, psel, penable, pwrite;
    logic [7:0]               paddr;
    logic [31:0]              pwdata, prdata;
    logic                     pready, pslverr, frame_start, in_ac_range, set_default_cmd;
    logic                     anticoll_mode, card_idle, wakeup_cmd;
    frlc_pkg::frlc_coll_evt_t coll_evt;
    frlc_pkg::frlc_rate_evt_t rate_evt;
    logic [12:0]              tx_byte_count;
    logic [2:0]               tx_split_bits;
    logic                     tx_parity_off, parity_irq, coll_parity_err;
    int                       num_errors, total_checks;
    localparam logic [7:0] A_COLL = {`FRLC_IDX_COLL, 2'b00};
    localparam logic [7:0] A_HI   = {`FRLC_IDX_CNT_HI, 2'b00};
    localparam logic [7:0] A_LO   = {`FRLC_IDX_CNT_LO, 2'b00};
    localparam logic [7:0] A_RATE = {`FRLC_IDX_RATE, 2'b00};

    always #2.5 pclk = ~pclk;

    frlc_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    frlc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_start(frame_start), .in_ac_range(in_ac_range),
        .coll_evt(coll_evt), .rate_evt(rate_evt), .set_default_cmd(set_default_cmd),
        .anticoll_mode(anticoll_mode), .card_idle(card_idle), .wakeup_cmd(wakeup_cmd),
        .tx_byte_count(tx_byte_count), .tx_split_bits(tx_split_bits),
        .tx_parity_off(tx_parity_off), .parity_irq(parity_irq),
        .coll_parity_err(coll_parity_err));

    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string msg);
        total_checks++;
        if (act !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, msg, act, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic        err, tmo;
        @(posedge pclk);
        i_host.xfer(w, a, d, rd, err, tmo);
        chk({31'h0, tmo}, 32'h0, "no answer");
        if (tmo) begin
            give_verdict();
        end
        chk({31'h0, err}, {31'h0, experr}, "slave error");
        if (!w && !experr) begin
            chk(rd, exp, "read data");
        end
    endtask

    task automatic coll(input logic [8:0] v, input logic fs, input logic rng);
        @(posedge pclk);
        frame_start <= fs;
        in_ac_range <= rng;
        @(posedge pclk);
        frame_start <= 1'b0;
        coll_evt    <= v;
        @(posedge pclk);
        coll_evt    <= 9'h000;
        #1;
    endtask

    task automatic t_counts();
        acc(1'b1, A_HI, 8'hff, 32'h0, 1'b0);
        acc(1'b1, A_LO, 8'hfd, 32'h0, 1'b0);
        acc(1'b0, A_HI, 8'h00, 32'hff, 1'b0);
        acc(1'b0, A_LO, 8'h00, 32'hfd, 1'b0);
        chk({19'h0, tx_byte_count}, 32'h1fff, "byte count");
        chk({29'h0, tx_split_bits}, 32'h5, "split bits");
        anticoll_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        #1 chk({31'h0, tx_parity_off}, 32'h1, "parity off");
        acc(1'b1, A_LO, 8'hf8, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, tx_parity_off}, 32'h0, "parity kept");
    endtask

    task automatic t_wake(input logic idle, input logic exp);
        @(posedge pclk);
        card_idle  <= idle;
        wakeup_cmd <= 1'b1;
        @(posedge pclk);
        wakeup_cmd <= 1'b0;
        #1 chk({31'h0, parity_irq}, {31'h0, exp}, "wake irq");
        @(posedge pclk);
        #1 chk({31'h0, parity_irq}, 32'h0, "wake irq end");
    endtask

    task automatic t_coll();
        coll({1'b1, 4'h3, 3'h5, 1'b1}, 1'b1, 1'b1);
        chk({31'h0, coll_parity_err}, 32'h1, "parity collision");
        coll({1'b1, 4'h7, 3'h2, 1'b1}, 1'b0, 1'b1);
        chk({31'h0, coll_parity_err}, 32'h0, "later collision");
        acc(1'b0, A_COLL, 8'h00, 32'h3b, 1'b0);
        coll({1'b1, 4'h1, 3'h1, 1'b0}, 1'b1, 1'b0);
        acc(1'b0, A_COLL, 8'h00, 32'h3b, 1'b0);
        coll({1'b1, 4'ha, 3'h6, 1'b0}, 1'b1, 1'b1);
        chk({31'h0, coll_parity_err}, 32'h0, "data collision");
        acc(1'b1, A_COLL, 8'hff, 32'h0, 1'b0);
        acc(1'b0, A_COLL, 8'h00, 32'hac, 1'b0);
    endtask

    task automatic t_rate();
        fork
            acc(1'b0, A_RATE, 8'h00, 32'hc0, 1'b0);
            begin
                @(posedge pclk);
                rate_evt <= {1'b1, 4'hc};
                @(posedge pclk);
                rate_evt <= 5'h00;
            end
        join
        acc(1'b1, A_RATE, 8'h0f, 32'h0, 1'b0);
        acc(1'b0, A_RATE, 8'h00, 32'hc0, 1'b0);
        acc(1'b0, 8'h80, 8'h00, 32'h0, 1'b1);
        acc(1'b1, 8'h6c, 8'h55, 32'h0, 1'b1);
    endtask

    task automatic t_regs_zero();
        acc(1'b0, A_COLL, 8'h00, 32'h0, 1'b0);
        acc(1'b0, A_HI, 8'h00, 32'h0, 1'b0);
        acc(1'b0, A_LO, 8'h00, 32'h0, 1'b0);
        acc(1'b0, A_RATE, 8'h00, 32'h0, 1'b0);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {frame_start, in_ac_range, set_default_cmd} = 3'h0;
        {anticoll_mode, card_idle, wakeup_cmd} = 3'h0;
        coll_evt = 9'h000;
        rate_evt = 5'h00;
        num_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs_zero();
        t_counts();
        t_wake(1'b1, 1'b0);
        acc(1'b1, A_LO, 8'h12, 32'h0, 1'b0);
        t_wake(1'b1, 1'b1);
        t_wake(1'b0, 1'b0);
        t_coll();
        t_rate();
        @(posedge pclk);
        set_default_cmd <= 1'b1;
        @(posedge pclk);
        set_default_cmd <= 1'b0;
        t_regs_zero();
        chk({19'h0, tx_byte_count}, 32'h0, "count cleared");
        give_verdict();
    end
endmodule
